//--- hw/flash_host_pkg.sv
// constants for the dual-bank parallel flash host controller
package flash_host_pkg;
	localparam int ADDR_W = 18;
	localparam int DATA_W = 16;
	// access timing in ns and derived cycles at 40 MHz
	localparam int CLK_NS = 25;
	localparam int T_ACC_NS = 120;
	localparam int T_WP_NS = 50;
	localparam int T_RST_NS = 500;
	localparam logic [4:0] ACC_CYC = 5'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [4:0] WP_CYC = 5'((T_WP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [4:0] RST_CYC = 5'((T_RST_NS + CLK_NS - 1) / CLK_NS);
	// host register offsets
	localparam logic [3:0] REG_ADDR = 4'h0;
	localparam logic [3:0] REG_DATA = 4'h1;
	localparam logic [3:0] REG_CMD = 4'h2;
	localparam logic [3:0] REG_STATUS = 4'h3;
	localparam logic [3:0] REG_RDATA = 4'h4;
	localparam logic [3:0] REG_CTRL = 4'h5;
	// command codes written to REG_CMD
	localparam logic [2:0] CMD_READ = 3'h0;
	localparam logic [2:0] CMD_WRITE = 3'h1;
	localparam logic [2:0] CMD_PROG = 3'h2;
	localparam logic [2:0] CMD_BYP_PROG = 3'h3;
	localparam logic [2:0] CMD_RESET = 3'h4;
	// unlock cycle addresses and data
	localparam logic [17:0] UNLK_A1 = 18'h00555;
	localparam logic [17:0] UNLK_A2 = 18'h002aa;
	localparam logic [15:0] UNLK_D1 = 16'h00aa;
	localparam logic [15:0] UNLK_D2 = 16'h0055;
	localparam logic [15:0] PROG_D = 16'h00a0;
	localparam logic [15:0] CTRL_RST = 16'h0001;
	typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_WR_SET, ST_WR_LOW, ST_WR_GAP, ST_RST}
		state_t;
endpackage

//--- hw/flash_host.sv
// host controller driving the dual-bank parallel flash over its pins
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - commands are plain write cycles latched by the device.
// - unlock bypass program takes two writes instead of four.
// - other bank is readable without suspending erase.
// - host may place device into standby.
// - reads drive chip select and output gate low, write strobe high; while standby_reg is set the host holds both high instead.
module flash_host
	import flash_host_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_ce,
	// register port
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	// flash pins
	output logic [17:0] o_fl_addr,
	input wire logic [15:0] i_fl_dq,
	output logic [15:0] o_fl_dq,
	output logic o_fl_dq_oe,
	output logic o_fl_ce_n,
	output logic o_fl_oe_n,
	output logic o_fl_we_n,
	output logic o_fl_reset_n,
	output logic o_fl_byte_n,
	input wire logic i_op_done_indicator_n
);
	state_t state_reg;
	logic [4:0] cnt_reg;
	logic [17:0] addr_reg;
	logic [15:0] data_reg;
	logic [15:0] rdata_reg;
	logic [15:0] out_reg;
	logic [2:0] seq_reg;
	logic [2:0] seq_len_reg;
	logic standby_reg;
	logic byte_mode_reg;
	logic rst_req;
	logic [17:0] cyc_addr;
	logic [15:0] cyc_data;
	logic busy;
	logic toggled_reg;
	logic [15:0] prev_rd_reg;

	assign busy = (state_reg != ST_IDLE);

	// address and data for each cycle of a command sequence
	always_comb
	begin
		cyc_addr = addr_reg;
		cyc_data = data_reg;
		if (seq_len_reg == 3'h4)
		begin
			case (seq_reg)
				3'h0: begin cyc_addr = UNLK_A1; cyc_data = UNLK_D1; end
				3'h1: begin cyc_addr = UNLK_A2; cyc_data = UNLK_D2; end
				3'h2: begin cyc_addr = UNLK_A1; cyc_data = PROG_D; end
				default: ;
			endcase
		end
		else if (seq_len_reg == 3'h2 && seq_reg == 3'h0)
		begin
			cyc_addr = addr_reg;
			cyc_data = PROG_D;
		end
	end

	// operand and control registers
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			addr_reg <= 18'h00000;
			data_reg <= 16'h0000;
			standby_reg <= 1'b0;
			byte_mode_reg <= 1'b0;
		end
		else if (i_ce && i_wr && !busy)
		begin
			if (i_addr == REG_ADDR)
				addr_reg <= {addr_reg[17:16], i_wdata};
			else if (i_addr == REG_DATA)
				data_reg <= i_wdata;
			else if (i_addr == REG_CTRL)
			begin
				standby_reg <= i_wdata[1];
				byte_mode_reg <= i_wdata[2];
				addr_reg[17:16] <= i_wdata[5:4];
			end
		end
	end

	assign rst_req = i_wr && i_addr == REG_CMD && i_wdata[2:0] == CMD_RESET;

	// bus cycle sequencer
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			state_reg <= ST_IDLE;
			cnt_reg <= 5'h00;
			seq_reg <= 3'h0;
			seq_len_reg <= 3'h0;
			rdata_reg <= 16'h0000;
		end
		else if (i_ce)
		begin
			case (state_reg)
				ST_IDLE:
				begin
					cnt_reg <= 5'h00;
					seq_reg <= 3'h0;
					if (rst_req)
						state_reg <= ST_RST;
					else if (i_wr && i_addr == REG_CMD && i_wdata[2:0] == CMD_READ)
						state_reg <= ST_RD;
					else if (i_wr && i_addr == REG_CMD && i_wdata[2:0] != CMD_RESET)
					begin
						state_reg <= ST_WR_SET;
						if (i_wdata[2:0] == CMD_PROG)
							seq_len_reg <= 3'h4;
						else if (i_wdata[2:0] == CMD_BYP_PROG)
							seq_len_reg <= 3'h2;
						else
							seq_len_reg <= 3'h1;
					end
				end
				ST_RD:
				begin
					cnt_reg <= cnt_reg + 5'h01;
					if (cnt_reg == ACC_CYC)
					begin
						rdata_reg <= i_fl_dq;
						state_reg <= ST_IDLE;
					end
				end
				ST_WR_SET:
				begin
					cnt_reg <= 5'h00;
					state_reg <= ST_WR_LOW;
				end
				ST_WR_LOW:
				begin
					cnt_reg <= cnt_reg + 5'h01;
					if (cnt_reg == WP_CYC)
						state_reg <= ST_WR_GAP;
				end
				ST_WR_GAP:
				begin
					if (seq_reg + 3'h1 >= seq_len_reg)
						state_reg <= ST_IDLE;
					else
					begin
						seq_reg <= seq_reg + 3'h1;
						state_reg <= ST_WR_SET;
					end
				end
				ST_RST:
				begin
					cnt_reg <= cnt_reg + 5'h01;
					if (cnt_reg == RST_CYC)
						state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// toggle detection over successive reads
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			prev_rd_reg <= 16'h0000;
			toggled_reg <= 1'b0;
		end
		else if (i_ce && state_reg == ST_RD && cnt_reg == ACC_CYC)
		begin
			prev_rd_reg <= i_fl_dq;
			toggled_reg <= prev_rd_reg[6] ^ i_fl_dq[6];
		end
	end

	// pin drive
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_fl_addr <= 18'h00000;
			o_fl_dq <= 16'h0000;
			o_fl_dq_oe <= 1'b0;
			o_fl_ce_n <= 1'b1;
			o_fl_oe_n <= 1'b1;
			o_fl_we_n <= 1'b1;
			o_fl_reset_n <= 1'b0;
		end
		else if (i_ce)
		begin
			o_fl_reset_n <= !(state_reg == ST_RST);
			o_fl_ce_n <= !(state_reg == ST_RD || state_reg == ST_WR_SET ||
				state_reg == ST_WR_LOW || state_reg == ST_WR_GAP) || standby_reg;
			o_fl_oe_n <= !(state_reg == ST_RD) || standby_reg;
			o_fl_we_n <= !(state_reg == ST_WR_LOW);
			o_fl_dq_oe <= (state_reg == ST_WR_SET || state_reg == ST_WR_LOW ||
				state_reg == ST_WR_GAP);
			o_fl_addr <= (state_reg == ST_RD) ? addr_reg : cyc_addr;
			o_fl_dq <= cyc_data;
			if (byte_mode_reg)
				o_fl_dq[15] <= addr_reg[0];
		end
	end
	assign o_fl_byte_n = !byte_mode_reg;

	// register read port
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			out_reg <= 16'h0000;
		else if (i_ce && i_rd)
		begin
			if (i_addr == REG_ADDR)
				out_reg <= addr_reg[15:0];
			else if (i_addr == REG_DATA)
				out_reg <= data_reg;
			else if (i_addr == REG_STATUS)
				out_reg <= {11'h000, rdata_reg[7] ^ data_reg[7], toggled_reg,
					!i_op_done_indicator_n, 1'b0, busy};
			else if (i_addr == REG_RDATA)
				out_reg <= rdata_reg;
			else if (i_addr == REG_CTRL)
				out_reg <= {10'h000, addr_reg[17:16], 1'b0, byte_mode_reg, standby_reg, 1'b0};
			else
				out_reg <= 16'h0000;
		end
	end
	assign o_rdata = out_reg;

	a_read_strobes: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!o_fl_oe_n |-> o_fl_we_n && !o_fl_ce_n)
		else $error("read cycle drove write strobe");
	a_write_no_gate: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!o_fl_we_n |-> o_fl_oe_n && o_fl_dq_oe)
		else $error("write cycle with output gate low");
	a_reset_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		$fell(o_fl_reset_n) |-> !o_fl_reset_n [*3])
		else $error("reset pulse too short");
	a_bypass_two: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		state_reg == ST_WR_GAP && seq_len_reg == 3'h2 |-> seq_reg <= 3'h1)
		else $error("bypass program exceeded two cycles");
	a_standby_idle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_ce && standby_reg && $stable(standby_reg) |=> o_fl_ce_n)
		else $error("chip select low in standby");
	a_byte_lsb: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!o_fl_we_n && !o_fl_byte_n |-> o_fl_dq[15] == addr_reg[0])
		else $error("byte mode select mismatch");
	a_done_status: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_ce && i_rd && i_addr == REG_STATUS |=> o_rdata[2] == $past(!i_op_done_indicator_n))
		else $error("ready pin not reported");
endmodule // flash_host
`default_nettype wire

//--- sim/flash_dev_model.sv
// behavioural model of the dual-bank flash device
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model
#(
	parameter int BUSY_NS = 3000
)
(
	input wire logic [17:0] i_addr,
	input wire logic [15:0] i_dq,
	input wire logic i_ce_n,
	input wire logic i_oe_n,
	input wire logic i_we_n,
	input wire logic i_reset_n,
	output logic [15:0] o_dq,
	output logic o_op_done_indicator_n
);
	logic [15:0] mem [16];
	logic [15:0] pdat;
	logic busy;
	logic tog;
	logic pbank;
	logic byp;
	int step;
	time done_at;
	initial
	begin
		foreach (mem[i]) mem[i] = 16'hffff;
		busy = 0;
		tog = 0;
		step = 0;
		byp = 0;
	end
	always @(posedge i_we_n or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			step = 0;
			busy = 0;
			byp = 0;
		end
		else if (!i_ce_n)
		begin
			if (step == 3)
			begin
				mem[i_addr[3:0]] = mem[i_addr[3:0]] & i_dq;
				pdat = i_dq;
				pbank = i_addr[17];
				busy = 1;
				done_at = $time + BUSY_NS;
				step = 0;
			end
			else if (step == 2 && i_addr == 18'h00555 && i_dq == 16'h0020)
			begin
				byp = 1;
				step = 0;
			end
			else if (byp && step == 0 && i_dq == 16'h00a0)
				step = 3;
			else if (i_addr == (step == 1 ? 18'h002aa : 18'h00555) &&
				i_dq == (step == 0 ? 16'h00aa : step == 1 ? 16'h0055 : 16'h00a0))
				step++;
			else
				step = 0;
		end
	end
	always #100 if (busy && $time >= done_at) busy = 0;
	always @(negedge i_oe_n) if (busy) tog = ~tog;
	assign o_op_done_indicator_n = ~busy;
	// busy bank gives status, other bank array data, released bus a moving pattern
	assign o_dq = (!i_ce_n && !i_oe_n && i_reset_n) ?
		((busy && i_addr[17] == pbank) ? {8'h00, ~pdat[7], tog, 6'h00}
		: mem[i_addr[3:0]]) : (16'h5aa5 ^ {16{tog}});
endmodule // flash_dev_model
`default_nettype wire

//--- sim/flash_host_tb.sv
// self-checking testbench for the flash host controller
`timescale 1ns/10ps
`default_nettype none
module flash_host_tb;
	import flash_host_pkg::*;
	logic i_clk, i_rst_b, i_ce, i_wr, i_rd;
	logic [3:0] i_addr;
	logic [15:0] i_wdata, o_rdata, o_fl_dq, dev_dq, dq_bus;
	logic [17:0] o_fl_addr;
	logic o_fl_dq_oe, o_fl_ce_n, o_fl_oe_n, o_fl_we_n, o_fl_reset_n, o_fl_byte_n, rdy_n;
	int miscompares = 0, comparisons = 0, we_cnt = 0, ce_cnt = 0;
	logic dq15_seen = 0;
	assign dq_bus = o_fl_dq_oe ? o_fl_dq : dev_dq;
	flash_host u_flash_host (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_fl_addr(o_fl_addr),
		.i_fl_dq(dq_bus), .o_fl_dq(o_fl_dq), .o_fl_dq_oe(o_fl_dq_oe), .o_fl_ce_n(o_fl_ce_n),
		.o_fl_oe_n(o_fl_oe_n), .o_fl_we_n(o_fl_we_n), .o_fl_reset_n(o_fl_reset_n),
		.o_fl_byte_n(o_fl_byte_n), .i_op_done_indicator_n(rdy_n));
	flash_dev_model u_flash_dev_model (.i_addr(o_fl_addr), .i_dq(dq_bus), .i_ce_n(o_fl_ce_n),
		.i_oe_n(o_fl_oe_n), .i_we_n(o_fl_we_n), .i_reset_n(o_fl_reset_n), .o_dq(dev_dq),
		.o_op_done_indicator_n(rdy_n));
	initial
	begin
		i_clk = 0;
		forever #12.5 i_clk = ~i_clk;
	end
	always @(negedge o_fl_we_n)
	begin
		we_cnt++;
		dq15_seen = o_fl_dq[15];
	end
	always @(negedge o_fl_ce_n) ce_cnt++;
	task automatic complete_run;
		$display("miscompares %0d comparisons %0d", miscompares, comparisons);
		if (miscompares == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	always @(posedge i_clk) if (i_rst_b && o_fl_oe_n === 1'b0) chk({15'h0, o_fl_we_n}, 16'h1);
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1;
		@(posedge i_clk);
		i_wr <= 0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1;
		@(posedge i_clk);
		i_rd <= 0;
		#1 d = o_rdata;
	endtask
	task automatic wait_bit(input int b, input logic v);
		logic [15:0] s;
		for (int n = 0; n < 300; n++)
		begin
			rd(REG_STATUS, s);
			if (s[b] === v) return;
		end
		miscompares++;
		complete_run();
	endtask
	task automatic start(input logic [15:0] a, input logic [15:0] d, input logic [2:0] c);
		wr(REG_ADDR, a);
		wr(REG_DATA, d);
		wr(REG_CMD, {13'h0, c});
		wait_bit(0, 0);
	endtask
	task automatic flash_rd(input logic [15:0] a, output logic [15:0] d);
		start(a, 16'h0000, CMD_READ);
		rd(REG_RDATA, d);
	endtask
	task automatic prog_seq;
		logic [15:0] d;
		we_cnt = 0;
		start(16'h0003, 16'h1234, CMD_PROG);
		chk(16'(we_cnt), 16'h4);
		rd(REG_STATUS, d);
		chk({15'h0, d[2]}, 16'h1);
		flash_rd(16'h0003, d);
		chk({15'h0, d[7]}, 16'h1);
		flash_rd(16'h0003, d);
		rd(REG_STATUS, d);
		chk({14'h0, d[4:3]}, 16'h3);
		wait_bit(2, 0);
		flash_rd(16'h0003, d);
		chk(d, 16'h1234);
		start(16'h0003, 16'hff0f, CMD_PROG);
		wait_bit(2, 0);
		flash_rd(16'h0003, d);
		chk(d, 16'h1204);
	endtask
	task automatic bypass_seq;
		logic [15:0] d;
		start(16'h0555, 16'h00aa, CMD_WRITE);
		start(16'h02aa, 16'h0055, CMD_WRITE);
		start(16'h0555, 16'h0020, CMD_WRITE);
		we_cnt = 0;
		start(16'h0007, 16'h5a5a, CMD_BYP_PROG);
		chk(16'(we_cnt), 16'h2);
		wait_bit(2, 0);
		flash_rd(16'h0007, d);
		chk(d, 16'h5a5a);
	endtask
	task automatic reset_seq;
		logic [15:0] d;
		start(16'h0005, 16'h00ff, CMD_PROG);
		wr(REG_CTRL, 16'h0020);
		flash_rd(16'h0005, d);
		chk(d, 16'h00ff);
		wr(REG_CTRL, 16'h0000);
		start(16'h0000, 16'h0000, CMD_RESET);
		rd(REG_STATUS, d);
		chk({15'h0, d[2]}, 16'h0);
		flash_rd(16'h0005, d);
		chk(d, 16'h00ff);
	endtask
	task automatic ctrl_seq;
		logic [15:0] d;
		ce_cnt = 0;
		wr(REG_CTRL, 16'h0002);
		flash_rd(16'h0001, d);
		chk(16'(ce_cnt), 16'h0);
		wr(REG_CTRL, 16'h0004);
		@(negedge i_clk);
		chk({15'h0, o_fl_byte_n}, 16'h0);
		start(16'h0001, 16'h0000, CMD_WRITE);
		chk({15'h0, dq15_seen}, 16'h1);
	endtask
	initial
	begin
		i_rst_b = 0;
		i_ce = 1;
		i_addr = 0;
		i_wdata = 0;
		i_wr = 0;
		i_rd = 0;
		repeat (10) @(posedge i_clk);
		i_rst_b <= 1;
		wr(REG_CTRL, 16'h0000);
		prog_seq();
		bypass_seq();
		reset_seq();
		ctrl_seq();
		complete_run();
	end
endmodule // flash_host_tb
`default_nettype wire
